// file: hdl/mic_pkg.sv
// constants shared by the interrupt controller files
package mic_pkg;
	// data memory addresses of the two control registers
	localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h0b;
	localparam logic [7:0] ADDR_CTRL_SECONDARY = 8'h1e;
	// primary register field positions
	localparam int BIT_MASTER_EN = 0;
	localparam int BIT_PIN_A_EN = 1;
	localparam int BIT_PIN_B_EN = 2;
	localparam int BIT_TIMER_EN = 3;
	localparam int BIT_PIN_A_FLAG = 4;
	localparam int BIT_PIN_B_FLAG = 5;
	localparam int BIT_TIMER_FLAG = 6;
	// secondary register field positions
	localparam int BIT_CONV_EN = 0;
	localparam int BIT_CONV_FLAG = 4;
	// values after reset
	localparam logic [7:0] RST_CTRL_PRIMARY = 8'h00;
	localparam logic [7:0] RST_CTRL_SECONDARY = 8'h00;
	// vectors in priority order
	localparam logic [10:0] VEC_PIN_A = 11'h004;
	localparam logic [10:0] VEC_PIN_B = 11'h008;
	localparam logic [10:0] VEC_TIMER = 11'h00c;
	localparam logic [10:0] VEC_CONV = 11'h010;
	localparam int NUM_SRC = 4;
endpackage

// file: hdl/mic_edge_detect.sv
// edge detector for one external request pin
`timescale 1ns/100ps
`default_nettype none
module mic_edge_detect
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// pin and option
	input wire logic pin,
	input wire logic pin_enable,
	input wire logic rising_sel,
	// one-cycle request pulse
	output logic edge_pulse
);
	logic prev_ff;
	logic nxt_prev;

	// remember last level
	always_comb
	begin
		nxt_prev = pin;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			prev_ff <= 1'b0;
		else
			prev_ff <= nxt_prev;
	end

	// pulse on the chosen transition only when the option enables the pin
	always_comb
	begin
		if (rising_sel)
			edge_pulse = pin_enable & pin & ~prev_ff;
		else
			edge_pulse = pin_enable & ~pin & prev_ff;
	end
endmodule // mic_edge_detect
`default_nettype wire

// file: hdl/mic_irq_ctrl.sv
// interrupt controller: flags, enables, priority, acknowledge and wake
// Function
// - four sources: two pins, timer overflow, converter overflow
// - acknowledge clears master enable; new requests still set flags
// - software re-enabling master and source allows nested acknowledge
// - no acknowledge while return stack is full
// - acknowledge pushes only program counter and branches to vector
// - every source can wake device from power-down
// - pins raise flags on configured edge; flags at primary bits 4 and 5
// - pin requests call 04H or 08H, clearing flag and master enable
// - timer overflow sets bit 6, calls 0CH, clears flag and master
// - converter timer A or B overflow sets bit 4, calls 10H
// - interrupt return sets master enable; plain return leaves it
// - requests sampled and serviced on next phase-two pulse
// - fixed priority pin A, pin B, timer, converter; master masks all
// - primary register at 0BH holds master, enables and three flags
// - secondary register at 1EH holds converter enable and flag
// - flags stay until serviced or cleared; enables never block setting
// - primary bits 0..3 master, pin A, pin B, timer enables; bit 7 zero
// - secondary bit 0 converter enable; other unused bits read zero
// - a flag already set at power-down entry gives no wake-up
`timescale 1ns/100ps
`default_nettype none
module mic_irq_ctrl
#(
	parameter int VEC_W = 11
)
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// external pins and their configuration options
	input wire logic EXT_IRQ_PIN_A,
	input wire logic EXT_IRQ_PIN_B,
	input wire logic PIN_A_OPT_ENABLE,
	input wire logic PIN_B_OPT_ENABLE,
	input wire logic PIN_A_OPT_RISING,
	input wire logic PIN_B_OPT_RISING,
	// internal overflow sources
	input wire logic TIMER_OVERFLOW,
	input wire logic CONV_TIMER_A_OVERFLOW,
	input wire logic CONV_TIMER_B_OVERFLOW,
	// data memory access from the core
	input wire logic [7:0] DATA_ADDR,
	input wire logic DATA_WR,
	input wire logic [7:0] DATA_WDATA,
	output logic [7:0] DATA_RDATA,
	// core sequencer
	input wire logic PHASE_TWO_PULSE,
	input wire logic STACK_FULL,
	input wire logic RETURN_FROM_ISR,
	input wire logic SUBROUTINE_RETURN,
	input wire logic POWER_DOWN_ENTER,
	input wire logic POWER_DOWN,
	// acknowledge to the core
	output logic IRQ_ACK,
	output logic [VEC_W-1:0] IRQ_VECTOR,
	output logic WAKE_UP
);
	logic [7:0] prim_ff, nxt_prim;
	logic [7:0] sec_ff, nxt_sec;
	logic [3:0] wake_mask_ff, nxt_wake_mask;
	logic ack_ff, nxt_ack;
	logic [VEC_W-1:0] vec_ff, nxt_vec;
	logic [7:0] rdata_ff, nxt_rdata;
	logic wake_ff, nxt_wake;
	logic edge_a, edge_b;
	logic [3:0] flags, enables, hw_set, sw_set, clr, pend;
	logic [1:0] win;
	logic grant;

	// encoded priority pick, lowest index wins
	function automatic logic [1:0] pick(input logic [3:0] req);
		logic [1:0] r;
		r = 2'h0;
		for (int i = mic_pkg::NUM_SRC - 1; i >= 0; i--)
			if (req[i])
				r = 2'(i);
		return r;
	endfunction

	function automatic logic [VEC_W-1:0] vector_of(input logic [1:0] s);
		logic [VEC_W-1:0] v;
		unique case (s)
			2'h0: v = VEC_W'(mic_pkg::VEC_PIN_A);
			2'h1: v = VEC_W'(mic_pkg::VEC_PIN_B);
			2'h2: v = VEC_W'(mic_pkg::VEC_TIMER);
			2'h3: v = VEC_W'(mic_pkg::VEC_CONV);
		endcase
		return v;
	endfunction

	mic_edge_detect u_edge_a
	(
		.clk(REF_CLK),
		.arst_n(ARST_N),
		.pin(EXT_IRQ_PIN_A),
		.pin_enable(PIN_A_OPT_ENABLE),
		.rising_sel(PIN_A_OPT_RISING),
		.edge_pulse(edge_a)
	);

	mic_edge_detect u_edge_b
	(
		.clk(REF_CLK),
		.arst_n(ARST_N),
		.pin(EXT_IRQ_PIN_B),
		.pin_enable(PIN_B_OPT_ENABLE),
		.rising_sel(PIN_B_OPT_RISING),
		.edge_pulse(edge_b)
	);

	// source vectors, index is priority order
	always_comb
	begin
		flags = {sec_ff[mic_pkg::BIT_CONV_FLAG],
			prim_ff[mic_pkg::BIT_TIMER_FLAG],
			prim_ff[mic_pkg::BIT_PIN_B_FLAG],
			prim_ff[mic_pkg::BIT_PIN_A_FLAG]};
		enables = {sec_ff[mic_pkg::BIT_CONV_EN],
			prim_ff[mic_pkg::BIT_TIMER_EN],
			prim_ff[mic_pkg::BIT_PIN_B_EN],
			prim_ff[mic_pkg::BIT_PIN_A_EN]};
		hw_set = {CONV_TIMER_A_OVERFLOW | CONV_TIMER_B_OVERFLOW,
			TIMER_OVERFLOW, edge_b, edge_a};
	end

	// masking and priority over the flagged requests
	always_comb
	begin
		// a flag raised since the last pulse is served at this one
		pend = flags & enables;
		win = pick(pend);
		// software re-arming master lets a nested request through
		grant = PHASE_TWO_PULSE & prim_ff[mic_pkg::BIT_MASTER_EN]
			& (|pend) & ~STACK_FULL;
	end

	// register writes, flag set and acknowledge side effects
	always_comb
	begin
		logic [3:0] newf;
		logic wr_p, wr_s;
		newf = '0;
		wr_p = DATA_WR && DATA_ADDR == mic_pkg::ADDR_CTRL_PRIMARY;
		wr_s = DATA_WR && DATA_ADDR == mic_pkg::ADDR_CTRL_SECONDARY;
		nxt_prim = prim_ff;
		nxt_sec = sec_ff;
		// software ones on flags count as requests
		sw_set = '0;
		clr = '0;
		if (wr_p)
		begin
			nxt_prim = {1'b0, DATA_WDATA[6:0]};
			sw_set[2:0] = DATA_WDATA[6:4];
		end
		if (wr_s)
		begin
			nxt_sec = '0;
			nxt_sec[mic_pkg::BIT_CONV_EN] = DATA_WDATA[mic_pkg::BIT_CONV_EN];
			sw_set[3] = DATA_WDATA[mic_pkg::BIT_CONV_FLAG];
		end
		// interrupt return re-arms master; plain return does not
		if (RETURN_FROM_ISR)
			nxt_prim[mic_pkg::BIT_MASTER_EN] = 1'b1;
		// acknowledge clears master and the served flag
		if (grant)
		begin
			nxt_prim[mic_pkg::BIT_MASTER_EN] = 1'b0;
			clr[win] = 1'b1;
		end
		newf = flags;
		if (wr_p)
			newf[2:0] = DATA_WDATA[6:4];
		if (wr_s)
			newf[3] = DATA_WDATA[mic_pkg::BIT_CONV_FLAG];
		// hardware set wins over any clear
		newf = (newf & ~clr) | hw_set | sw_set;
		nxt_prim[mic_pkg::BIT_PIN_A_FLAG] = newf[0];
		nxt_prim[mic_pkg::BIT_PIN_B_FLAG] = newf[1];
		nxt_prim[mic_pkg::BIT_TIMER_FLAG] = newf[2];
		nxt_sec[mic_pkg::BIT_CONV_FLAG] = newf[3];
		nxt_prim[7] = 1'b0;
		nxt_sec[7:5] = 3'h0;
		nxt_sec[3:1] = 3'h0;
	end

	// acknowledge strobe and vector; core pushes only the PC
	always_comb
	begin
		nxt_ack = grant;
		nxt_vec = vec_ff;
		if (grant)
			nxt_vec = vector_of(win);
	end

	// sources flagged at power-down entry cannot wake
	always_comb
	begin
		nxt_wake_mask = wake_mask_ff;
		if (POWER_DOWN_ENTER)
			nxt_wake_mask = ~flags;
		// a hardware event from a source not flagged at entry wakes the device during power-down
		nxt_wake = POWER_DOWN & |(hw_set & wake_mask_ff);
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = 8'h00;
		if (DATA_ADDR == mic_pkg::ADDR_CTRL_PRIMARY)
			nxt_rdata = prim_ff;
		else if (DATA_ADDR == mic_pkg::ADDR_CTRL_SECONDARY)
			nxt_rdata = sec_ff;
	end

	// all state registers
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			prim_ff <= mic_pkg::RST_CTRL_PRIMARY;
			sec_ff <= mic_pkg::RST_CTRL_SECONDARY;
			wake_mask_ff <= 4'hf;
			ack_ff <= 1'b0;
			vec_ff <= '0;
			rdata_ff <= 8'h00;
			wake_ff <= 1'b0;
		end
		else
		begin
			prim_ff <= nxt_prim;
			sec_ff <= nxt_sec;
			wake_mask_ff <= nxt_wake_mask;
			ack_ff <= nxt_ack;
			vec_ff <= nxt_vec;
			rdata_ff <= nxt_rdata;
			wake_ff <= nxt_wake;
		end
	end

	assign IRQ_ACK = ack_ff;
	assign IRQ_VECTOR = vec_ff;
	assign DATA_RDATA = rdata_ff;
	assign WAKE_UP = wake_ff;

	a_ack_clears_master: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		grant && !RETURN_FROM_ISR && !DATA_WR
		|=> !prim_ff[mic_pkg::BIT_MASTER_EN])
		else $error("master enable not cleared on acknowledge");
	a_full_no_ack: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		STACK_FULL |=> !IRQ_ACK)
		else $error("acknowledge while stack full");
	a_ack_on_phase: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		IRQ_ACK |-> $past(PHASE_TWO_PULSE))
		else $error("acknowledge without phase-two pulse");
	a_ack_one_cycle: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		IRQ_ACK |=> !IRQ_ACK)
		else $error("acknowledge strobe longer than one cycle");
	a_return_from_isr_sets_master: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		RETURN_FROM_ISR && !grant && !DATA_WR
		|=> prim_ff[mic_pkg::BIT_MASTER_EN])
		else $error("interrupt return did not set master");
	a_timer_flag_set: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		TIMER_OVERFLOW |=> prim_ff[mic_pkg::BIT_TIMER_FLAG])
		else $error("timer flag not set");
	a_pin_a_first: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		grant && pend[0] |=> IRQ_VECTOR == VEC_W'(mic_pkg::VEC_PIN_A))
		else $error("priority order broken");
	a_prim_bit7_zero: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		!prim_ff[7] && !sec_ff[7])
		else $error("unused bit set");
	// an enabled flag at a pulse is acknowledged on the next cycle
	a_pend_served: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		PHASE_TWO_PULSE && prim_ff[mic_pkg::BIT_MASTER_EN]
		&& (|(flags & enables)) && !STACK_FULL |=> IRQ_ACK)
		else $error("enabled request not served at phase-two pulse");
	a_no_ack_masked: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		!prim_ff[mic_pkg::BIT_MASTER_EN] |=> !IRQ_ACK)
		else $error("acknowledge with master enable off");
	// a set flag stays until served or written
	a_flag_holds: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		prim_ff[mic_pkg::BIT_PIN_A_FLAG] && !grant && !DATA_WR
		|=> prim_ff[mic_pkg::BIT_PIN_A_FLAG])
		else $error("request flag lost");
	// converter timer B raises the converter flag
	a_conv_flag_set: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		CONV_TIMER_B_OVERFLOW |=> sec_ff[mic_pkg::BIT_CONV_FLAG])
		else $error("converter flag not set");
	a_pin_b_vector: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		grant && win == 2'h1 |=> IRQ_VECTOR == VEC_W'(mic_pkg::VEC_PIN_B))
		else $error("wrong vector for second pin");
	a_timer_vector: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		grant && win == 2'h2 |=> IRQ_VECTOR == VEC_W'(mic_pkg::VEC_TIMER))
		else $error("wrong vector for timer");
	a_conv_vector: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		grant && win == 2'h3 |=> IRQ_VECTOR == VEC_W'(mic_pkg::VEC_CONV))
		else $error("wrong vector for converter");
	// serving clears the flag unless a fresh edge arrives with it
	a_ack_clears_flag: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		grant && win == 2'h0 && !edge_a && !DATA_WR
		|=> !prim_ff[mic_pkg::BIT_PIN_A_FLAG])
		else $error("served flag not cleared");
	// a source event during power-down wakes the device
	a_wake_on_event: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		POWER_DOWN && TIMER_OVERFLOW && wake_mask_ff[2] |=> WAKE_UP)
		else $error("no wake-up on source event");
	// masked or absent events never wake
	a_no_wake_flagged: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		!(|(hw_set & wake_mask_ff)) |=> !WAKE_UP)
		else $error("wake-up from a source flagged at entry");
	a_sec_unused_zero: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		sec_ff[3:1] == 3'h0 && sec_ff[7:5] == 3'h0)
		else $error("unused secondary bit set");
	// a software one on a flag sets it
	a_sw_flag_set: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		DATA_WR && DATA_ADDR == mic_pkg::ADDR_CTRL_PRIMARY
		&& DATA_WDATA[mic_pkg::BIT_TIMER_FLAG]
		|=> prim_ff[mic_pkg::BIT_TIMER_FLAG])
		else $error("software flag write ignored");
	// plain return leaves master as it was
	a_ret_keeps_master: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		SUBROUTINE_RETURN && !RETURN_FROM_ISR && !grant && !DATA_WR
		|=> prim_ff[mic_pkg::BIT_MASTER_EN]
		== $past(prim_ff[mic_pkg::BIT_MASTER_EN]))
		else $error("plain return changed master enable");
	a_vec_stable: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
		!grant |=> $stable(IRQ_VECTOR))
		else $error("vector changed without acknowledge");
endmodule // mic_irq_ctrl
`default_nettype wire

// file: bench/mic_core_model.sv
// core sequencer and return stack model facing the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module mic_core_model
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// requests from the bench
	input wire logic slow,
	input wire logic call_rq,
	input wire logic ret_rq,
	input wire logic ret_isr,
	// controller side
	input wire logic irq_ack,
	output logic phase_two_pulse,
	output logic stack_full,
	output logic return_from_isr,
	output logic subroutine_return
);
	logic [2:0] cnt_ff;
	logic [2:0] depth_ff;
	// phase pulse every four cycles, or eight when slow to stress sampling
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_ff <= 3'h0;
		else
			cnt_ff <= (slow || cnt_ff != 3'h3) ? cnt_ff + 3'h1 : 3'h0;
	end
	assign phase_two_pulse = (cnt_ff == 3'h0);
	// four levels; calls come from main code only, never in a handler
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			depth_ff <= 3'h0;
		else
			depth_ff <= depth_ff + {2'h0, irq_ack | call_rq} - {2'h0, ret_rq};
	end
	assign stack_full = (depth_ff == 3'h4);
	// a return pops one level; its kind decides the master enable
	assign return_from_isr = ret_rq & ret_isr;
	assign subroutine_return = ret_rq & ~ret_isr;
endmodule // mic_core_model
`default_nettype wire

// file: bench/mic_irq_ctrl_tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module mic_irq_ctrl_tb_top;
	logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, pde = 1'b0, pd = 1'b0;
	logic pa = 1'b0, pb = 1'b0, oa = 1'b0, ob = 1'b0, ra = 1'b0, rb = 1'b0;
	logic tmr = 1'b0, cva = 1'b0, cvb = 1'b0, slow = 1'b0;
	logic call_rq = 1'b0, ret_rq = 1'b0, risr = 1'b0;
	logic ack, wake, p2, sfull, rti, sret;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
	logic [10:0] vec;
	logic [10:0] exp_q[$];
	int err_count = 0, cmp_count = 0, wakes = 0, seed = 32'h74df, i;
	// free-running 10 MHz clock
	always #50 clk = ~clk;
	mic_irq_ctrl mic_irq_ctrl_inst (.REF_CLK(clk), .ARST_N(arst_n),
		.EXT_IRQ_PIN_A(pa), .EXT_IRQ_PIN_B(pb), .PIN_A_OPT_ENABLE(oa),
		.PIN_B_OPT_ENABLE(ob), .PIN_A_OPT_RISING(ra), .PIN_B_OPT_RISING(rb),
		.TIMER_OVERFLOW(tmr), .CONV_TIMER_A_OVERFLOW(cva),
		.CONV_TIMER_B_OVERFLOW(cvb), .DATA_ADDR(addr), .DATA_WR(wr),
		.DATA_WDATA(wdata), .DATA_RDATA(rdata), .PHASE_TWO_PULSE(p2),
		.STACK_FULL(sfull), .RETURN_FROM_ISR(rti), .SUBROUTINE_RETURN(sret),
		.POWER_DOWN_ENTER(pde), .POWER_DOWN(pd), .IRQ_ACK(ack),
		.IRQ_VECTOR(vec), .WAKE_UP(wake));
	mic_core_model mic_core_model_inst (.clk(clk), .arst_n(arst_n),
		.slow(slow), .call_rq(call_rq), .ret_rq(ret_rq), .ret_isr(risr),
		.irq_ack(ack), .phase_two_pulse(p2), .stack_full(sfull),
		.return_from_isr(rti), .subroutine_return(sret));
	task chk(input logic [10:0] seen, input logic [10:0] exp);
		cmp_count++;
		if (seen !== exp)
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		if (seen !== exp)
			err_count++;
	endtask
	task results;
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pls(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task wrr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// read data is registered, so it is looked at one cycle after the address
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		chk({3'h0, rdata}, {3'h0, e});
	endtask
	// bounded wait until every expected acknowledge has been seen
	task automatic wack;
		int n;
		for (n = 0; n < 60 && exp_q.size() > 0; n++)
			@(negedge clk);
		chk(11'(exp_q.size()), 11'h000);
		exp_q.delete();
	endtask
	// each acknowledge takes the oldest expected vector; a stray one fails
	always @(negedge clk)
	begin
		if (ack === 1'b1)
			chk(vec, (exp_q.size() > 0) ? exp_q.pop_front() : 11'h7ff);
		if (wake === 1'b1)
			wakes++;
	end
	// main sequence
	initial
	begin
		cyc(16);
		arst_n = 1'b1;
		rd(8'h0b, mic_pkg::RST_CTRL_PRIMARY);
		rd(8'h1e, mic_pkg::RST_CTRL_SECONDARY);
		rd(8'h05, 8'h00);
		// random contents with the master enable kept off
		for (i = 0; i < 4; i++)
		begin
			r = 8'($random(seed)) & 8'h7e;
			wrr(8'h0b, r);
			rd(8'h0b, r);
			r = 8'($random(seed));
			wrr(8'h1e, r);
			rd(8'h1e, r & 8'h11);
		end
		wrr(8'h1e, 8'h00);
		// falling then rising sense on both pins; the wrong edge sets nothing
		for (i = 0; i < 2; i++)
		begin
			pa = ~i[0];
			pb = ~i[0];
			ra = i[0];
			rb = i[0];
			oa = 1'b1;
			ob = 1'b1;
			cyc(3);
			wrr(8'h0b, 8'h00);
			pa = i[0];
			cyc(3);
			rd(8'h0b, 8'h10);
			pb = i[0];
			cyc(3);
			rd(8'h0b, 8'h30);
			wrr(8'h0b, 8'h00);
			pa = ~i[0];
			pb = ~i[0];
			cyc(3);
			rd(8'h0b, 8'h00);
		end
		// all four pending at once, served one by one in priority order
		wrr(8'h1e, 8'h01);
		wrr(8'h0b, 8'h3e);
		pls(tmr);
		pls(cvb);
		cyc(12);
		rd(8'h0b, 8'h7e);
		rd(8'h1e, 8'h11);
		exp_q.push_back(mic_pkg::VEC_PIN_A);
		wrr(8'h0b, 8'h7f);
		wack;
		rd(8'h0b, 8'h6e);
		exp_q.push_back(mic_pkg::VEC_PIN_B);
		wrr(8'h0b, 8'h6f);
		wack;
		risr = 1'b1;
		exp_q.push_back(mic_pkg::VEC_TIMER);
		pls(ret_rq);
		wack;
		exp_q.push_back(mic_pkg::VEC_CONV);
		pls(ret_rq);
		wack;
		pls(ret_rq);
		pls(ret_rq);
		rd(8'h0b, 8'h0f);
		// full stack holds the request back until a plain return
		wrr(8'h0b, 8'h08);
		slow = 1'b1;
		risr = 1'b0;
		repeat (4) pls(call_rq);
		wrr(8'h0b, 8'h09);
		pls(tmr);
		cyc(40);
		rd(8'h0b, 8'h49);
		exp_q.push_back(mic_pkg::VEC_TIMER);
		pls(ret_rq);
		wack;
		rd(8'h0b, 8'h08);
		pls(ret_rq);
		cyc(20);
		rd(8'h0b, 8'h08);
		slow = 1'b0;
		// wake from power-down, then none when the flag was already set
		wrr(8'h1e, 8'h01);
		pls(pde);
		pd = 1'b1;
		pls(cva);
		cyc(4);
		chk(11'(wakes), 11'h001);
		pd = 1'b0;
		pls(pde);
		pd = 1'b1;
		pls(cva);
		cyc(4);
		chk(11'(wakes), 11'h001);
		pd = 1'b0;
		results;
	end
	// watchdog well beyond the expected run length
	initial
	begin
		#(100 * 4000);
		err_count++;
		results;
	end
endmodule // mic_irq_ctrl_tb_top
`default_nettype wire
